// ---- eps_selector.sv ----
// Exception priority selector: picks one pending, unmasked exception per grant.
// Assumes sources hold their pending level until the entry logic consumes it,
// and that the entry logic pulses accept when it starts servicing the grant.
`timescale 1ns/1ps
`default_nettype none
module eps_selector (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Translation and mode context
	input  wire logic        xlate_on,
	input  wire logic        user_mode,
	input  wire logic        float_enable_bit,
	input  wire logic        aux_unit_enable_bit,
	input  wire logic        user_attr_exc_enable,
	// Machine check and debug
	input  wire logic        mchk_data_bus_err,
	input  wire logic        instr_addr_match_event,
	input  wire logic        mchk_fetch_bus_err,
	input  wire logic        exception_debug_event,
	input  wire logic        unconditional_debug_event,
	input  wire logic        branch_taken_event,
	input  wire logic        data_addr_match_event,
	input  wire logic        data_value_match_event,
	input  wire logic        instr_completion_event,
	input  wire logic        trap_debug_event,
	// External inputs and timers
	input  wire logic        crit_input,
	input  wire logic        watchdog_timeout,
	input  wire logic        ext_input,
	input  wire logic        fit_timeout,
	input  wire logic        pit_timeout,
	// Instruction side
	input  wire logic        itlb_no_match,
	input  wire logic        fetch_zone_noaccess,
	input  wire logic        fetch_page_noexec,
	input  wire logic        fetch_page_guarded,
	// Program and system call
	input  wire logic        illegal_instr,
	input  wire logic        fp_unimpl_instr,
	input  wire logic        aux_unimpl_instr,
	input  wire logic        priv_instr,
	input  wire logic        trap_satisfied,
	input  wire logic        system_call_instr,
	input  wire logic        fp_impl_instr,
	input  wire logic        aux_impl_instr,
	// Data side
	input  wire logic        dtlb_no_match,
	input  wire logic        data_zone_noaccess,
	input  wire logic        store_op,
	input  wire logic        page_read_only,
	input  wire logic        user_defined_page_attr,
	input  wire logic        bzero_uncached,
	input  wire logic        reserve_misaligned,
	input  wire logic        cache_read_misaligned,
	// Per-cause interrupt enables; a zero bit masks that cause
	input  wire logic [31:0] cause_enable,
	// Entry logic has started servicing the current grant
	input  wire logic        accept,
	output logic             grant_valid,
	output logic [4:0]       grant_cause,
	output logic [4:0]       grant_level,
	output logic             grant_critical,
	output logic [31:0]      pending_status
);

	logic [31:0] raw;
	logic [31:0] eligible;
	wire         pick_any;
	wire  [4:0]  pick_idx;

	// Qualify each cause by its own condition
	assign raw[eps_pkg::C_MCHK_DATA]     = mchk_data_bus_err;
	assign raw[eps_pkg::C_DBG_IAC]       = instr_addr_match_event;
	assign raw[eps_pkg::C_MCHK_INSTR]    = mchk_fetch_bus_err;
	assign raw[eps_pkg::C_DBG_EXC]       = exception_debug_event;
	assign raw[eps_pkg::C_DBG_UNCOND]    = unconditional_debug_event;
	assign raw[eps_pkg::C_CRIT_INPUT]    = crit_input;
	assign raw[eps_pkg::C_WATCHDOG]      = watchdog_timeout;
	assign raw[eps_pkg::C_ITLB_MISS]     = itlb_no_match & xlate_on;
	assign raw[eps_pkg::C_ISTOR_NOACC]   = fetch_zone_noaccess & user_mode & xlate_on;
	assign raw[eps_pkg::C_ISTOR_NOEXEC]  = fetch_page_noexec & xlate_on;
	assign raw[eps_pkg::C_ISTOR_GUARD]   = fetch_page_guarded;
	assign raw[eps_pkg::C_PROG_ILLEGAL]  = illegal_instr;
	assign raw[eps_pkg::C_PROG_FP_UNIMP] = fp_unimpl_instr;
	assign raw[eps_pkg::C_PROG_AUX_UNIM] = aux_unimpl_instr;
	assign raw[eps_pkg::C_PROG_PRIV]     = priv_instr & user_mode;
	assign raw[eps_pkg::C_PROG_TRAP]     = trap_satisfied;
	assign raw[eps_pkg::C_SYSCALL]       = system_call_instr;
	assign raw[eps_pkg::C_FP_UNAVAIL]    = fp_impl_instr & ~float_enable_bit;
	assign raw[eps_pkg::C_AUX_UNAVAIL]   = aux_impl_instr & ~aux_unit_enable_bit;
	assign raw[eps_pkg::C_DTLB_MISS]     = dtlb_no_match & xlate_on;
	assign raw[eps_pkg::C_DSTOR_NOACC]   = data_zone_noaccess & user_mode & xlate_on;
	assign raw[eps_pkg::C_DSTOR_RDONLY]  = store_op & page_read_only & xlate_on;
	assign raw[eps_pkg::C_DSTOR_USERDEF] = store_op & user_defined_page_attr
		& user_attr_exc_enable;
	// Cache-read misalignment only counts in privileged mode
	assign raw[eps_pkg::C_ALIGNMENT]     = bzero_uncached | reserve_misaligned
		| (cache_read_misaligned & ~user_mode);
	assign raw[eps_pkg::C_DBG_BRANCH]    = branch_taken_event;
	assign raw[eps_pkg::C_DBG_DADDR]     = data_addr_match_event;
	assign raw[eps_pkg::C_DBG_DVALUE]    = data_value_match_event;
	assign raw[eps_pkg::C_DBG_ICOMPL]    = instr_completion_event;
	assign raw[eps_pkg::C_DBG_TRAP]      = trap_debug_event;
	assign raw[eps_pkg::C_EXTERNAL]      = ext_input;
	assign raw[eps_pkg::C_FIT]           = fit_timeout;
	assign raw[eps_pkg::C_PIT]           = pit_timeout;

	// Masked causes drop out rather than blocking lower ones
	assign eligible = raw & cause_enable;

	// Index order equals level order, ties by listed order
	eps_first_set #(
		.N(32),
		.W(5)
	) u_pick (
		.req(eligible),
		.any(pick_any),
		.idx(pick_idx)
	);

	// Hold a grant until accepted, so its number never shifts under the
	// entry logic; a fresh choice is made only when no grant is standing.
	logic        valid_q;
	logic        valid_d;
	logic [4:0]  cause_q;
	logic [4:0]  cause_d;
	logic [4:0]  level_q;
	logic [4:0]  level_d;
	logic        crit_q;
	logic        crit_d;
	logic [31:0] status_q;
	wire         load_new;

	assign load_new = ~valid_q | accept;
	assign valid_d  = load_new ? (pick_any & ~accept) : valid_q;
	assign cause_d  = (load_new & pick_any & ~accept) ? pick_idx : cause_q;
	assign level_d  = (load_new & pick_any & ~accept)
		? eps_pkg::eps_level_of(pick_idx) : level_q;
	assign crit_d   = (load_new & pick_any & ~accept)
		? eps_pkg::eps_is_critical(pick_idx) : crit_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			valid_q  <= 1'b0;
			cause_q  <= eps_pkg::RST_CAUSE;
			level_q  <= eps_pkg::RST_LEVEL;
			crit_q   <= 1'b0;
			status_q <= '0;
		end else begin
			valid_q  <= valid_d;
			cause_q  <= cause_d;
			level_q  <= level_d;
			crit_q   <= crit_d;
			status_q <= raw;
		end
	end

	// Accept cycle empties the slot; the next choice follows one cycle later,
	// which gives sources a cycle to drop the serviced request.
	assign grant_valid    = valid_q;
	assign grant_cause    = cause_q;
	assign grant_level    = level_q;
	assign grant_critical = crit_q;
	assign pending_status = status_q;

endmodule
`default_nettype wire

// ---- eps_pkg.sv ----
// Package for the exception priority selector: cause indices, levels, classes.
// Assumes a single core clock domain; no registers are bus mapped.
package eps_pkg;

	// Number of individual causes and of priority levels
	localparam int NUM_CAUSES = 32;
	localparam int NUM_LEVELS = 18;
	localparam int CAUSE_W    = 5;
	localparam int LEVEL_W    = 5;

	// Cause indices; lower index is served first
	localparam logic [4:0] C_MCHK_DATA     = 5'h00;
	localparam logic [4:0] C_DBG_IAC       = 5'h01;
	localparam logic [4:0] C_MCHK_INSTR    = 5'h02;
	localparam logic [4:0] C_DBG_EXC       = 5'h03;
	localparam logic [4:0] C_DBG_UNCOND    = 5'h04;
	localparam logic [4:0] C_CRIT_INPUT    = 5'h05;
	localparam logic [4:0] C_WATCHDOG      = 5'h06;
	localparam logic [4:0] C_ITLB_MISS     = 5'h07;
	localparam logic [4:0] C_ISTOR_NOACC   = 5'h08;
	localparam logic [4:0] C_ISTOR_NOEXEC  = 5'h09;
	localparam logic [4:0] C_ISTOR_GUARD   = 5'h0a;
	localparam logic [4:0] C_PROG_ILLEGAL  = 5'h0b;
	localparam logic [4:0] C_PROG_FP_UNIMP = 5'h0c;
	localparam logic [4:0] C_PROG_AUX_UNIM = 5'h0d;
	localparam logic [4:0] C_PROG_PRIV     = 5'h0e;
	localparam logic [4:0] C_PROG_TRAP     = 5'h0f;
	localparam logic [4:0] C_SYSCALL       = 5'h10;
	localparam logic [4:0] C_FP_UNAVAIL    = 5'h11;
	localparam logic [4:0] C_AUX_UNAVAIL   = 5'h12;
	localparam logic [4:0] C_DTLB_MISS     = 5'h13;
	localparam logic [4:0] C_DSTOR_NOACC   = 5'h14;
	localparam logic [4:0] C_DSTOR_RDONLY  = 5'h15;
	localparam logic [4:0] C_DSTOR_USERDEF = 5'h16;
	localparam logic [4:0] C_ALIGNMENT     = 5'h17;
	localparam logic [4:0] C_DBG_BRANCH    = 5'h18;
	localparam logic [4:0] C_DBG_DADDR     = 5'h19;
	localparam logic [4:0] C_DBG_DVALUE    = 5'h1a;
	localparam logic [4:0] C_DBG_ICOMPL    = 5'h1b;
	localparam logic [4:0] C_DBG_TRAP      = 5'h1c;
	localparam logic [4:0] C_EXTERNAL      = 5'h1d;
	localparam logic [4:0] C_FIT           = 5'h1e;
	// Programmable-interval timer occupies the last index
	localparam logic [4:0] C_PIT           = 5'h1f;

	// Reset values of the grant outputs
	localparam logic [4:0] RST_CAUSE = 5'h00;
	localparam logic [4:0] RST_LEVEL = 5'h00;

	// Priority level (1 = highest) of each cause index
	function automatic logic [4:0] eps_level_of(input logic [4:0] c);
		logic [4:0] l;
		l = 5'h00;
		case (c)
			5'h00: l = 5'h01;
			5'h01: l = 5'h02;
			5'h02: l = 5'h03;
			5'h03, 5'h04: l = 5'h04;
			5'h05: l = 5'h05;
			5'h06: l = 5'h06;
			5'h07: l = 5'h07;
			5'h08: l = 5'h08;
			5'h09, 5'h0a: l = 5'h09;
			5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12: l = 5'h0a;
			5'h13: l = 5'h0b;
			5'h14: l = 5'h0c;
			5'h15, 5'h16: l = 5'h0d;
			5'h17: l = 5'h0e;
			5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c: l = 5'h0f;
			5'h1d: l = 5'h10;
			5'h1e: l = 5'h11;
			default: l = 5'h12;
		endcase
		return l;
	endfunction

	// Critical class: machine check, debug, critical input, watchdog
	function automatic logic eps_is_critical(input logic [4:0] c);
		return (c <= 5'h06) || (c >= 5'h18 && c <= 5'h1c);
	endfunction

endpackage

// ---- eps_first_set.sv ----
// Priority picker: lowest set index of a request vector.
// Pure combinational; used by the selector top.
`timescale 1ns/1ps
`default_nettype none
module eps_first_set #(
	parameter int N = 32,
	parameter int W = 5
) (
	input  wire logic [N-1:0] req,
	output logic              any,
	output logic [W-1:0]      idx
);
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = W'(i);
			end
		end
	end
endmodule
`default_nettype wire

// ---- eps_selector_assertions.sv ----
// Checker for the exception priority selector, bound to its top module.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module eps_selector_assertions (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [31:0] cause_enable,
	input wire logic        accept,
	input wire logic        grant_valid,
	input wire logic [4:0]  grant_cause,
	input wire logic [4:0]  grant_level,
	input wire logic        grant_critical,
	input wire logic [31:0] pending_status
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// All causes, masked or not, that would outrank the granted one
	wire logic [31:0] above = (32'h1 << grant_cause) - 32'h1;
	// Enables as they stood on the edge that chose the grant
	logic [31:0] enable_q;

	always_ff @(posedge sys_clk) begin
		enable_q <= cause_enable;
	end

	chk_grant_holds: assert property (
		grant_valid && !accept |=> grant_valid && $stable(grant_cause))
		else $error("grant changed before accept");
	chk_accept_gap: assert property (grant_valid && accept |=> !grant_valid)
		else $error("grant still valid after accept");
	chk_first_pick: assert property (
		$rose(grant_valid) |-> pending_status[grant_cause]
		&& ((pending_status & enable_q & above) == 32'h0))
		else $error("grant is not the first eligible cause");
	chk_mask_skip: assert property (grant_valid |-> cause_enable[grant_cause])
		else $error("masked cause granted");
	chk_top_level: assert property (
		grant_valid && grant_cause == 5'h00 |-> grant_level == 5'h01 && grant_critical)
		else $error("data machine check not level one");
	chk_last_level: assert property (
		grant_valid && grant_cause == 5'h1f |-> grant_level == 5'h12 && !grant_critical)
		else $error("interval timer not level eighteen");
	chk_level_order: assert property (
		grant_valid |-> grant_level >= 5'h01 && grant_level <= 5'h12
		&& {1'b0, grant_level} <= {1'b0, grant_cause} + 6'h01)
		else $error("level out of order");
	chk_crit_class: assert property (
		grant_valid |-> grant_critical
		== (grant_cause <= 5'h06 || (grant_cause >= 5'h18 && grant_cause <= 5'h1c)))
		else $error("wrong class on grant");
	cover property ($rose(grant_valid) && grant_critical);
	cover property ($rose(grant_valid) && !cause_enable[0] && grant_cause == 5'h07);
	cover property (grant_valid && accept && grant_cause == 5'h1f);
endmodule
bind eps_selector eps_selector_assertions i_eps_selector_assertions (.sys_clk(sys_clk),
	.reset(reset), .cause_enable(cause_enable), .accept(accept), .grant_valid(grant_valid),
	.grant_cause(grant_cause), .grant_level(grant_level), .grant_critical(grant_critical),
	.pending_status(pending_status));
`default_nettype wire

// ---- eps_entry_model.sv ----
// Handler-entry model: consumes each grant with a one-cycle accept pulse.
// Assumes grant_valid is a registered level; dly sets the service latency.
`timescale 1ns/1ps
`default_nettype none
module eps_entry_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [3:0] dly,
	input  wire logic       grant_valid,
	output logic            accept = 1'b0
);
	logic [3:0] wait_q = 4'h0;
	// One grant in service at a time; accept drops once the grant is taken
	always @(negedge sys_clk) begin
		if (reset || !grant_valid || accept) begin
			accept <= 1'b0;
			wait_q <= 4'h0;
		end else if (wait_q == dly) begin
			accept <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- exception_priority_selector_tb.sv ----
// Testbench for the exception priority selector, one task per scenario.
// Assumes the entry model and checker compile first; 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module exception_priority_selector_tb;
	logic        sys_clk = 1'b0;
	logic        reset   = 1'b1;
	logic [31:0] raw     = 32'h0;
	logic [31:0] en      = 32'hffffffff;
	logic        xl = 1'b1, um = 1'b1, fe = 1'b0, ae = 1'b0;
	logic        st = 1'b1, ue = 1'b1, cr = 1'b0;
	logic [3:0]  dly     = 4'h0;
	wire logic        accept, grant_valid, grant_critical;
	wire logic [4:0]  grant_cause, grant_level;
	wire logic [31:0] pending_status;
	int mismatches = 0;
	int check_count = 0;
	localparam logic [4:0] LV [32] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h09, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a,
		5'h0b, 5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0f, 5'h0f, 5'h0f, 5'h0f, 5'h0f, 5'h10, 5'h11, 5'h12};
	always #5 sys_clk = ~sys_clk;

	eps_entry_model i_eps_entry_model (.sys_clk(sys_clk), .reset(reset), .dly(dly),
		.grant_valid(grant_valid), .accept(accept));
	eps_selector i_eps_selector (.sys_clk(sys_clk), .reset(reset), .xlate_on(xl),
		.user_mode(um), .float_enable_bit(fe), .aux_unit_enable_bit(ae),
		.user_attr_exc_enable(ue), .mchk_data_bus_err(raw[0]),
		.instr_addr_match_event(raw[1]), .mchk_fetch_bus_err(raw[2]),
		.exception_debug_event(raw[3]), .unconditional_debug_event(raw[4]),
		.crit_input(raw[5]), .watchdog_timeout(raw[6]), .itlb_no_match(raw[7]),
		.fetch_zone_noaccess(raw[8]), .fetch_page_noexec(raw[9]), .fetch_page_guarded(raw[10]),
		.illegal_instr(raw[11]), .fp_unimpl_instr(raw[12]), .aux_unimpl_instr(raw[13]),
		.priv_instr(raw[14]), .trap_satisfied(raw[15]), .system_call_instr(raw[16]),
		.fp_impl_instr(raw[17]), .aux_impl_instr(raw[18]), .dtlb_no_match(raw[19]),
		.data_zone_noaccess(raw[20]), .store_op(st), .page_read_only(raw[21]),
		.user_defined_page_attr(raw[22]), .bzero_uncached(raw[23]),
		.reserve_misaligned(raw[23]), .cache_read_misaligned(cr),
		.branch_taken_event(raw[24]), .data_addr_match_event(raw[25]),
		.data_value_match_event(raw[26]), .instr_completion_event(raw[27]),
		.trap_debug_event(raw[28]), .ext_input(raw[29]), .fit_timeout(raw[30]),
		.pit_timeout(raw[31]), .cause_enable(en), .accept(accept), .grant_valid(grant_valid),
		.grant_cause(grant_cause), .grant_level(grant_level), .grant_critical(grant_critical),
		.pending_status(pending_status));

	task automatic final_report();
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic ok);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: cause %0d level %0d", $time, grant_cause, grant_level);
		end
	endtask

	task automatic wait_gv(input logic v);
		int n;
		for (n = 0; n < 20 && grant_valid !== v; n++) @(negedge sys_clk);
		if (grant_valid !== v) begin
			mismatches++;
			final_report();
		end
	endtask

	// Source holds its cause until the grant is consumed, then drops it
	task automatic serve(input int c);
		logic crit;
		crit = (c <= 6 || (c >= 24 && c <= 28));
		wait_gv(1'b1);
		check(grant_cause === 5'(c) && grant_level === LV[c] && grant_critical === crit);
		wait_gv(1'b0);
		raw[c] = 1'b0;
	endtask

	task automatic walk_each();
		for (int c = 0; c < 32; c++) begin
			raw[c] = 1'b1;
			serve(c);
		end
	endtask

	task automatic mask_skip();
		en = 32'hffffff80;
		raw = 32'h800000ff;
		serve(7);
		check(pending_status === 32'h800000ff);
		serve(31);
		en = 32'hffffffff;
		for (int c = 0; c < 7; c++) serve(c);
	endtask

	// Slow entry logic with every cause pending: strictly one per grant
	task automatic all_pending();
		dly = 4'h3;
		raw = 32'hffffffff;
		for (int c = 0; c < 32; c++) serve(c);
		dly = 4'h0;
	endtask

	// Causes that need translation, user mode or a clear enable bit stay quiet
	task automatic qualify_off();
		xl = 1'b0;
		um = 1'b0;
		fe = 1'b1;
		ae = 1'b1;
		ue = 1'b0;
		cr = 1'b1;
		raw = 32'h807e4380;
		serve(23);
		cr = 1'b0;
		serve(31);
		repeat (2) @(negedge sys_clk);
		check(pending_status === 32'h0 && grant_valid === 1'b0);
		// Loads never raise the store-only causes
		xl = 1'b1;
		ue = 1'b1;
		st = 1'b0;
		raw = 32'h00600000;
		repeat (2) @(negedge sys_clk);
		check(pending_status === 32'h0 && grant_valid === 1'b0);
		raw = 32'h0;
		st = 1'b1;
		{xl, um, fe, ae} = 4'hc;
	endtask

	// Reset in mid-run drops a standing grant; service resumes afterwards
	task automatic reset_mid();
		raw = 32'h00000001;
		wait_gv(1'b1);
		reset = 1'b1;
		@(negedge sys_clk);
		check(grant_valid === 1'b0 && grant_level === eps_pkg::RST_LEVEL && pending_status === 32'h0);
		reset = 1'b0;
		serve(0);
	endtask

	initial begin
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		walk_each();
		mask_skip();
		all_pending();
		qualify_off();
		reset_mid();
		final_report();
	end
endmodule
`default_nettype wire
